// ===== hdl/mbl_load_ctrl.sv
// Contract
// [R1] on the final load request, write the block's data into the mirror array
// [R2] host may stream the next block while this one is loading
// [R3] release busy once the block has been written to the array
// [R4] host starts the global mirror pulse after busy releases
// [R5] hold mirror pulse active while a pulse operation runs
// [R6] host delays next first-block request until mirrors settle
// [R7] host sends next control word only after the previous load request
// [R8] drive busy low on accepting a load request
// [R9] host request no earlier than 300ns after first data packet
// [R10] host measures the 300ns from the first lane valid cycle
// [R11] host opens every block with a control word
// [R12] support block clear 001 and block set 010 without data
// [R13] for clear or set, 300ns counts from the control word
// [R14] during block set all lane valids stay low
// [R15] partial blocks load only the rows delivered
// [R16] normal mode spreads row data across all four lanes
// [R17] single channel mode uses lane 0 only
// [R18] host sets single flag and sends segments 3, 2, 1, 0
// [R19] single mode: only segment 0 loads; no busy for 3, 2, 1
// [R20] host issues no request while busy is low; the testbench issues one with ignore_busy set
`timescale 1ns/1ps
`default_nettype none

module mbl_load_ctrl #(
    parameter int LANES      = 4,
    parameter int LANE_W     = 192,
    parameter int BLOCK_ROWS = 64
) (
    input  wire logic                              core_clk_i,
    input  wire logic                              rst_i,
    input  wire logic [mbl_pkg::REG_ADDR_W-1:0]    reg_addr_i,
    input  wire logic [mbl_pkg::REG_DATA_W-1:0]    reg_wdata_i,
    input  wire logic                              reg_wr_i,
    input  wire logic                              reg_rd_i,
    output logic      [mbl_pkg::REG_DATA_W-1:0]    reg_rdata_o,
    input  wire logic                              ctrl_valid_i,
    input  wire logic [mbl_pkg::CW_W-1:0]          ctrl_word_i,
    input  wire logic [LANES-1:0]                  lane_tx_valid_i,
    input  wire logic [LANES*LANE_W-1:0]           lane_data_i,
    input  wire logic                              array_load_request_i,
    input  wire logic                              mirror_pulse_start_i,
    output logic                                   block_load_busy_n_o,
    output logic                                   mirror_pulse_active_o,
    output logic                                   array_wr_en_o,
    output logic      [$clog2(BLOCK_ROWS)-1:0]     array_row_o,
    output logic      [LANES*LANE_W-1:0]           array_data_o,
    output logic      [mbl_pkg::CW_SEG_W-1:0]      array_segment_index_o
);
    import mbl_pkg::*;

    localparam int RW = $clog2(BLOCK_ROWS);
    localparam logic [RW:0] ROWS_MAX = (RW+1)'(BLOCK_ROWS);

    mbl_state_t state_q;
    logic                   req_s1_q, req_s2_q, req_s3_q;
    logic                   start_s1_q, start_s2_q, start_s3_q;
    logic [CW_W-1:0]        cw_q;
    logic [RW:0]            wr_row_q;
    logic                   wr_bank_q, ld_bank_q;
    logic [CW_OP_W-1:0]     ld_op_q;
    logic [RW:0]            ld_rows_q, rd_row_q;
    logic [RW-1:0]          pend_row_q;
    logic                   rd_pend_q;
    logic                   en_q;
    logic [PULSE_LEN_W-1:0] pulse_len_q, pulse_cnt_q;
    logic [LOADS_W-1:0]     loads_q;
    logic [LANES*LANE_W-1:0] mem_rdata;

    // control word fields
    wire [CW_OP_W-1:0]   cw_op     = cw_q[CW_OP_LSB +: CW_OP_W];
    wire                 cw_single = cw_q[CW_SINGLE_BIT];
    wire [CW_SEG_W-1:0]  cw_seg    = cw_q[CW_SEG_LSB +: CW_SEG_W];
    wire [CW_ROWS_W-1:0] cw_rows   = cw_q[CW_ROWS_LSB +: CW_ROWS_W];

    wire req_rise   = req_s2_q & ~req_s3_q;
    wire start_rise = start_s2_q & ~start_s3_q;
    wire idle       = (state_q == ST_IDLE);
    wire seg_final  = ~cw_single | (cw_seg == SEG_LAST);
    // request while busy is ignored
    wire accept     = idle & req_rise & en_q & seg_final; // [R8] [R19] [R20]

    // row capture into the bank not being loaded
    wire lanes_ok   = cw_single ? lane_tx_valid_i[0] : &lane_tx_valid_i; // [R16] [R17]
    wire row_we     = lanes_ok & (cw_op == OP_LOAD) & (wr_row_q < ROWS_MAX);
    wire [LANES-1:0] lane_mask = cw_single ? LANES'(1) << cw_seg : {LANES{1'b1}}; // [R17]
    wire [LANES*LANE_W-1:0] wdata =
        cw_single ? {LANES{lane_data_i[LANE_W-1:0]}} : lane_data_i;
    wire [LANES-1:0] mem_we = row_we ? lane_mask : '0;

    // rows to load: delivered rows for data, row field for clear/set
    wire [RW:0] cw_rows_clip = (cw_rows == '0 || cw_rows > CW_ROWS_W'(BLOCK_ROWS))
                               ? ROWS_MAX : (RW+1)'(cw_rows);
    wire [RW:0] rows_next    = (cw_op == OP_LOAD) ? wr_row_q : cw_rows_clip; // [R15]

    wire rd_en   = (state_q == ST_LOAD) & (rd_row_q < ld_rows_q);
    wire ld_done = (state_q == ST_LOAD) & (rd_row_q == ld_rows_q) & ~rd_pend_q;

    wire [LANES*LANE_W-1:0] fill =
        (ld_op_q == OP_SET) ? {LANES*LANE_W{1'b1}} :
        (ld_op_q == OP_CLEAR) ? '0 : mem_rdata; // [R12]

    wire [PULSE_LEN_W-1:0] pulse_cnt_d =
        start_rise ? pulse_len_q :
        (pulse_cnt_q != '0) ? pulse_cnt_q - PULSE_LEN_W'(1) : pulse_cnt_q;

    wire [REG_DATA_W-1:0] status_word = REG_DATA_W'({cw_seg, cw_single, wr_bank_q,
        mirror_pulse_active_o, ~block_load_busy_n_o}) ;
    wire [REG_DATA_W-1:0] rd_mux =
        (reg_addr_i == REG_CTRL)   ? REG_DATA_W'(en_q) :
        (reg_addr_i == REG_STATUS) ? status_word :
        (reg_addr_i == REG_LOADS)  ? REG_DATA_W'(loads_q) :
        (reg_addr_i == REG_PULSE)  ? REG_DATA_W'(pulse_len_q) : '0;

    mbl_row_mem #(
        .LANES  (LANES),
        .LANE_W (LANE_W),
        .AW     (RW + 1)
    ) u_mem (
        .core_clk_i (core_clk_i),
        .we_i       (mem_we),
        .waddr_i    ({wr_bank_q, wr_row_q[RW-1:0]}),
        .wdata_i    (wdata),
        .re_i       (rd_en),
        .raddr_i    ({ld_bank_q, rd_row_q[RW-1:0]}),
        .rdata_o    (mem_rdata)
    );

    // pin synchronisers
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {req_s1_q, req_s2_q, req_s3_q}       <= '0;
            {start_s1_q, start_s2_q, start_s3_q} <= '0;
        end else begin
            {req_s1_q, req_s2_q, req_s3_q}       <= {array_load_request_i, req_s1_q, req_s2_q};
            {start_s1_q, start_s2_q, start_s3_q} <= {mirror_pulse_start_i, start_s1_q,
                                                     start_s2_q};
        end
    end

    // control word and row write pointer
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cw_q     <= '0;
            wr_row_q <= '0;
        end else if (ctrl_valid_i) begin
            cw_q     <= ctrl_word_i; // [R11]
            wr_row_q <= '0;
        end else if (row_we) begin
            wr_row_q <= wr_row_q + (RW+1)'(1);
        end
    end

    // load sequencer
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q               <= ST_IDLE;
            wr_bank_q             <= 1'b0;
            ld_bank_q             <= 1'b0;
            ld_op_q               <= OP_LOAD;
            ld_rows_q             <= '0;
            rd_row_q              <= '0;
            array_segment_index_o <= '0;
            block_load_busy_n_o   <= 1'b1;
            loads_q               <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (accept) begin
                        state_q               <= ST_LOAD;
                        ld_op_q               <= cw_op;
                        ld_rows_q             <= rows_next; // [R15]
                        ld_bank_q             <= wr_bank_q;
                        wr_bank_q             <= ~wr_bank_q; // [R2]
                        rd_row_q              <= '0;
                        array_segment_index_o <= cw_seg;
                        block_load_busy_n_o   <= 1'b0; // [R8]
                    end
                end
                ST_LOAD: begin
                    if (rd_en) begin
                        rd_row_q <= rd_row_q + (RW+1)'(1); // [R1]
                    end
                    if (ld_done) begin
                        state_q             <= ST_IDLE;
                        block_load_busy_n_o <= 1'b1; // [R3]
                        loads_q             <= loads_q + LOADS_W'(1);
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // array write stage
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_pend_q     <= 1'b0;
            pend_row_q    <= '0;
            array_wr_en_o <= 1'b0;
            array_row_o   <= '0;
            array_data_o  <= '0;
        end else begin
            rd_pend_q     <= rd_en;
            pend_row_q    <= rd_row_q[RW-1:0];
            array_wr_en_o <= rd_pend_q; // [R1]
            array_row_o   <= pend_row_q;
            array_data_o  <= rd_pend_q ? fill : '0;
        end
    end

    // mirror pulse timer
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pulse_cnt_q           <= '0;
            mirror_pulse_active_o <= 1'b0;
        end else begin
            pulse_cnt_q           <= pulse_cnt_d;
            mirror_pulse_active_o <= (pulse_cnt_d != '0); // [R5]
        end
    end

    // register port
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            en_q        <= CTRL_EN_RESET;
            pulse_len_q <= PULSE_LEN_W'(PULSE_CYC);
            reg_rdata_o <= '0;
        end else begin
            if (reg_wr_i && reg_addr_i == REG_CTRL) begin
                en_q <= reg_wdata_i[CTRL_EN_BIT];
            end
            if (reg_wr_i && reg_addr_i == REG_PULSE) begin
                pulse_len_q <= reg_wdata_i[PULSE_LEN_W-1:0];
            end
            reg_rdata_o <= reg_rd_i ? rd_mux : '0;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_accept;
        idle && req_rise && en_q && seg_final;
    endsequence

    sequence s_busy_hold;
        !block_load_busy_n_o [*2];
    endsequence

    a_busy_on_accept: // [R8]
        assert property (s_accept |=> s_busy_hold or (!block_load_busy_n_o && ld_done))
        else $error("busy not driven low after accepted request");

    a_busy_release: // [R3]
        assert property (ld_done
                         |=> block_load_busy_n_o && !array_wr_en_o)
        else $error("busy not released after load completed");

    a_busy_only_load: // [R3]
        assert property (!block_load_busy_n_o |-> state_q == ST_LOAD)
        else $error("busy low outside a load");

    a_seg_no_busy: // [R19]
        assert property (idle && req_rise && cw_single && cw_seg != SEG_LAST
                         |=> block_load_busy_n_o && idle)
        else $error("busy asserted for a non-final segment");

    a_pulse_active: // [R5]
        assert property (start_rise && pulse_len_q > PULSE_LEN_W'(2)
                         |=> mirror_pulse_active_o [*2])
        else $error("mirror pulse active not held");

    a_pulse_ends: // [R5]
        assert property (mirror_pulse_active_o && pulse_cnt_q == PULSE_LEN_W'(1) && !start_rise
                         |=> !mirror_pulse_active_o)
        else $error("mirror pulse active past its count");

    a_load_writes: // [R1]
        assert property (s_accept ##1 (ld_rows_q != '0) |-> ##[1:3] array_wr_en_o)
        else $error("accepted load wrote no rows");

    a_clear_zero: // [R12]
        assert property (array_wr_en_o && ld_op_q == OP_CLEAR |-> array_data_o == '0)
        else $error("block clear wrote non-zero data");

    a_set_ones: // [R12]
        assert property (array_wr_en_o && ld_op_q == OP_SET |-> &array_data_o)
        else $error("block set wrote non-one data");

    a_rows_bound: // [R15]
        assert property (rd_en |-> rd_row_q < ld_rows_q && ld_rows_q <= ROWS_MAX)
        else $error("load ran past delivered rows");

    a_single_lane: // [R17]
        assert property (row_we && cw_single |-> $onehot(mem_we))
        else $error("single mode wrote more than one lane slot");

endmodule

`default_nettype wire

// ===== hdl/mbl_pkg.sv
package mbl_pkg;

    // core clock and mirror pulse timing
    localparam int CLK_PERIOD_NS = 40;
    localparam int PULSE_NS      = 2000;
    localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_LEN_W   = 16;

    // block control word layout
    localparam int CW_W          = 16;
    localparam int CW_OP_LSB     = 0;
    localparam int CW_OP_W       = 3;
    localparam int CW_SINGLE_BIT = 3;
    localparam int CW_SEG_LSB    = 4;
    localparam int CW_SEG_W      = 2;
    localparam int CW_ROWS_LSB   = 8;
    localparam int CW_ROWS_W     = 8;

    // load operation codes
    localparam logic [CW_OP_W-1:0]  OP_LOAD  = 3'h0;
    localparam logic [CW_OP_W-1:0]  OP_CLEAR = 3'h1;
    localparam logic [CW_OP_W-1:0]  OP_SET   = 3'h2;
    localparam logic [CW_SEG_W-1:0] SEG_LAST = 2'h0;

    // register port
    localparam int REG_ADDR_W = 4;
    localparam int REG_DATA_W = 32;
    localparam logic [REG_ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h4;
    localparam logic [REG_ADDR_W-1:0] REG_LOADS  = 4'h8;
    localparam logic [REG_ADDR_W-1:0] REG_PULSE  = 4'hC;
    localparam int CTRL_EN_BIT    = 0;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int LOADS_W        = 16;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_PULSE_BIT   = 1;
    localparam int ST_BANK_BIT    = 2;
    localparam int ST_SINGLE_BIT  = 3;
    localparam int ST_SEG_LSB     = 4;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_LOAD = 2'b10
    } mbl_state_t;

endpackage

// ===== hdl/mbl_row_mem.sv
`timescale 1ns/1ps
`default_nettype none

module mbl_row_mem #(
    parameter int LANES  = 4,
    parameter int LANE_W = 192,
    parameter int AW     = 7
) (
    input  wire logic                    core_clk_i,
    input  wire logic [LANES-1:0]        we_i,
    input  wire logic [AW-1:0]           waddr_i,
    input  wire logic [LANES*LANE_W-1:0] wdata_i,
    input  wire logic                    re_i,
    input  wire logic [AW-1:0]           raddr_i,
    output logic      [LANES*LANE_W-1:0] rdata_o
);

    for (genvar g = 0; g < LANES; g++) begin : g_lane
        logic [LANE_W-1:0] mem [2**AW];

        always_ff @(posedge core_clk_i) begin
            if (we_i[g]) begin
                mem[waddr_i] <= wdata_i[g*LANE_W +: LANE_W];
            end
            if (re_i) begin
                rdata_o[g*LANE_W +: LANE_W] <= mem[raddr_i];
            end
        end
    end

endmodule

`default_nettype wire

// ===== tb/mbl_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module mbl_host_model #(
    parameter int LW         = 8,
    parameter int SETUP_NS   = 300,
    parameter int SETTLE_CYC = 4
) (
    input  wire logic          core_clk_i,
    input  wire logic          busy_n_i,
    output logic               ctrl_valid_o,
    output logic [15:0]        ctrl_word_o,
    output logic [3:0]         lane_valid_o,
    output logic [4*LW-1:0]    lane_data_o,
    output logic               load_req_o,
    output logic               pulse_start_o
);
    realtime t_first = 0.0;

    initial begin
        ctrl_valid_o  = 1'b0;
        ctrl_word_o   = 16'h0000;
        lane_valid_o  = 4'h0;
        lane_data_o   = '0;
        load_req_o    = 1'b0;
        pulse_start_o = 1'b0;
    end

    task automatic send_word(input logic [15:0] cw);
        @(posedge core_clk_i);
        ctrl_valid_o <= 1'b1;
        ctrl_word_o  <= cw;
        t_first = $realtime;
        @(posedge core_clk_i);
        ctrl_valid_o <= 1'b0;
        ctrl_word_o  <= ~cw;
    endtask

    task automatic send_row(input logic [3:0] mask, input logic [4*LW-1:0] d, input bit first);
        @(posedge core_clk_i);
        lane_valid_o <= mask;
        lane_data_o  <= d;
        if (first) begin
            t_first = $realtime;
        end
    endtask

    // released lanes show the inverse of the last beat
    task automatic lanes_idle();
        @(posedge core_clk_i);
        lane_valid_o <= 4'h0;
        lane_data_o  <= ~lane_data_o;
    endtask

    task automatic request(input bit ignore_busy);
        while (!ignore_busy && busy_n_i !== 1'b1) begin
            @(posedge core_clk_i);
        end
        while ($realtime - t_first < SETUP_NS) begin
            @(posedge core_clk_i);
        end
        @(posedge core_clk_i);
        load_req_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        load_req_o <= 1'b0;
    endtask

    task automatic pulse();
        while (busy_n_i !== 1'b1) begin
            @(posedge core_clk_i);
        end
        @(posedge core_clk_i);
        pulse_start_o <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        pulse_start_o <= 1'b0;
        repeat (SETTLE_CYC) @(posedge core_clk_i);
    endtask
endmodule

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import mbl_pkg::*;
    localparam int LW = 8;
    localparam int DW = 4 * LW;
    logic                  core_clk_i = 1'b0;
    logic                  rst_i      = 1'b1;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [REG_DATA_W-1:0] reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic                  rd_d       = 1'b0;
    logic                  busy_seen  = 1'b0;
    logic [REG_DATA_W-1:0] reg_rdata;
    logic [CW_W-1:0]       ctrl_word;
    logic [3:0]            lane_valid;
    logic [DW-1:0]         lane_data, adata;
    logic [DW-1:0]         slot = '0;
    logic [2:0]            row;
    logic [1:0]            seg;
    logic                  ctrl_valid, load_req, pulse_start, busy_n, pulse_act, wr_en;
    logic [63:0]           exp_rd[$];
    logic [63:0]           exp_wr[$];
    int                    err_total = 0;
    int                    checks_done = 0;
    int                    cycles = 0;
    int                    seed = 32'h0e11;

    always #20 core_clk_i = ~core_clk_i;

    mbl_host_model #(.LW(LW)) host (
        .core_clk_i(core_clk_i), .busy_n_i(busy_n), .ctrl_valid_o(ctrl_valid),
        .ctrl_word_o(ctrl_word), .lane_valid_o(lane_valid), .lane_data_o(lane_data),
        .load_req_o(load_req), .pulse_start_o(pulse_start)
    );

    mbl_load_ctrl #(.LANE_W(LW), .BLOCK_ROWS(8)) dut (
        .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
        .reg_rdata_o(reg_rdata), .ctrl_valid_i(ctrl_valid), .ctrl_word_i(ctrl_word),
        .lane_tx_valid_i(lane_valid), .lane_data_i(lane_data),
        .array_load_request_i(load_req), .mirror_pulse_start_i(pulse_start),
        .block_load_busy_n_o(busy_n), .mirror_pulse_active_o(pulse_act),
        .array_wr_en_o(wr_en), .array_row_o(row), .array_data_o(adata),
        .array_segment_index_o(seg)
    );

    task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results();
        $display("mismatches %0d comparisons %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge core_clk_i) begin
        rd_d <= reg_rd;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            err_total++;
            results();
        end
    end

    // results are matched against the oldest note
    always @(negedge core_clk_i) begin
        if (busy_n === 1'b0) begin
            busy_seen = 1'b1;
        end
        if (rd_d) begin
            chk("reg_rdata", reg_rdata, exp_rd.size() ? exp_rd.pop_front() : 64'bx);
        end
        if (wr_en !== 1'b0) begin
            chk("array_write", {row, adata}, exp_wr.size() ? exp_wr.pop_front() : 64'bx);
        end
    end

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge core_clk_i);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk_i);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        exp_rd.push_back(e);
        @(posedge core_clk_i);
        reg_rd   <= 1'b0;
    endtask

    // busy is only looked at on falling edges, where it has settled
    task automatic wait_busy(input logic lvl, input int n, input string nm);
        int i;
        i = 0;
        @(negedge core_clk_i);
        while (i < n && busy_n !== lvl) begin
            @(negedge core_clk_i);
            i++;
        end
        chk(nm, busy_n, lvl);
    endtask

    task automatic count_pulse();
        int n;
        n = 0;
        repeat (16) begin
            @(negedge core_clk_i);
            n += (pulse_act === 1'b1);
        end
        chk("pulse_len", n, 3);
    endtask

    // the second row of a normal block follows a partial-lane beat that must be dropped
    task automatic send_block(input logic [2:0] op, input int n, input logic sgl,
                              input logic [1:0] s);
        logic [DW-1:0] d;
        host.send_word({n[7:0], 2'b00, s, sgl, op});
        for (int i = 0; i < n; i++) begin
            if (op == OP_LOAD) begin
                d = $random(seed);
                if (i == 1 && !sgl) begin
                    host.send_row(4'h7, ~d, 1'b0);
                end
                host.send_row(sgl ? 4'h1 : 4'hF, d, i == 0);
                slot[s*LW +: LW] = d[LW-1:0];
                if (!sgl) begin
                    exp_wr.push_back({i[2:0], d});
                end
            end else begin
                exp_wr.push_back({i[2:0], (op == OP_SET) ? {DW{1'b1}} : {DW{1'b0}}});
            end
        end
        if (sgl && s == SEG_LAST) begin
            exp_wr.push_back({3'h0, slot});
        end
        host.lanes_idle();
    endtask

    initial begin
        reg_addr  <= '0;
        reg_wdata <= '0;
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        rst_i <= 1'b0;
        @(negedge core_clk_i);
        chk("busy_rst", busy_n, 1'b1);
        chk("pulse_rst", pulse_act, 1'b0);
        reg_read(REG_CTRL, 32'h1);
        reg_read(REG_PULSE, 32'h32);
        reg_write(REG_STATUS, $random(seed));
        reg_write(4'h2, $random(seed));
        reg_read(REG_STATUS, 32'h0);
        reg_read(4'h2, 32'h0);
        reg_write(REG_PULSE, 32'h3);
        reg_read(REG_PULSE, 32'h3);
        send_block(OP_LOAD, 3, 1'b0, 2'h0);
        host.request(1'b0);
        wait_busy(1'b0, 8, "busy_a");
        // segment field is latched even in normal mode
        send_block(OP_LOAD, 4, 1'b0, 2'h2);
        wait_busy(1'b1, 20, "done_a");
        reg_read(REG_LOADS, 32'h1);
        host.request(1'b0);
        host.request(1'b1);
        wait_busy(1'b1, 20, "done_b");
        chk("seg_index", seg, 2'h2);
        fork
            host.pulse();
            count_pulse();
        join
        for (int k = 0; k < 2; k++) begin
            send_block(k ? OP_SET : OP_CLEAR, k + 2, 1'b0, 2'h0);
            host.request(1'b0);
            wait_busy(1'b0, 8, "busy_op");
            wait_busy(1'b1, 20, "done_op");
        end
        for (int s = 3; s >= 0; s--) begin
            busy_seen = 1'b0;
            send_block(OP_LOAD, 1, 1'b1, s[1:0]);
            host.request(1'b0);
            repeat (8) @(negedge core_clk_i);
            chk("busy_single", busy_seen, s == 0);
        end
        wait_busy(1'b1, 20, "done_single");
        chk("seg_single", seg, SEG_LAST);
        // five accepts so far leave the write bank at one
        reg_read(REG_STATUS, (32'h1 << ST_SINGLE_BIT) | (32'h1 << ST_BANK_BIT));
        reg_write(REG_CTRL, 32'h0);
        busy_seen = 1'b0;
        send_block(OP_CLEAR, 1, 1'b0, 2'h0);
        host.request(1'b0);
        repeat (8) @(negedge core_clk_i);
        chk("busy_disabled", busy_seen, 1'b0);
        reg_write(REG_CTRL, 32'h1);
        host.request(1'b0);
        wait_busy(1'b0, 8, "busy_enabled");
        wait_busy(1'b1, 20, "done_enabled");
        reg_read(REG_LOADS, 32'h6);
        repeat (4) @(negedge core_clk_i);
        chk("writes_left", exp_wr.size(), 0);
        results();
    end
endmodule

`default_nettype wire
